// file: bench/ehsp_params_properties.sv
// Purpose: port checks for the structural parameter register
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every ehsp_params instance
`timescale 1ns/1ps
`default_nettype none
module ehsp_params_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic port_indicator_out,
    input wire logic handoff_enable_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire logic hit = rd_en_in && addr_in == 8'h04;
    AST_ANSWER: assert property (rd_en_in |=> rd_valid_out)
        else $error("read not answered");
    AST_QUIET: assert property (!rd_en_in |=> !rd_valid_out)
        else $error("answer without read");
    AST_OTHER: assert property (rd_en_in && addr_in != 8'h04 |=>
        rd_data_out == 32'h0) else $error("other offset nonzero");
    AST_RSVD: assert property ((rd_data_out & 32'hFF0E_0060) == 32'h0)
        else $error("reserved bit set");
    AST_FIXED: assert property (hit |=> rd_data_out[15:0] == 16'h2294)
        else $error("fixed fields wrong");
    AST_DPN: assert property (hit |=> rd_data_out[23:20] <= rd_data_out[3:0])
        else $error("debug port above port count");
    AST_IND: assert property (hit |=> rd_data_out[16] == port_indicator_out)
        else $error("indicator bit mismatch");
    AST_FROZEN: assert property (!$past(rst_in) |-> $stable(port_indicator_out))
        else $error("indicator moved after reset");
    AST_HAND: assert property (handoff_enable_out)
        else $error("hand-off not enabled");
    cover property (hit ##1 hit);
    cover property (rd_en_in && addr_in != 8'h04);
    cover property (hit && port_indicator_out);
endmodule
bind ehsp_params ehsp_params_properties ehsp_params_properties_inst (
    .clock_in(clock_in), .rst_in(rst_in), .rd_en_in(rd_en_in),
    .addr_in(addr_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .port_indicator_out(port_indicator_out),
    .handoff_enable_out(handoff_enable_out));
`default_nettype wire

// file: bench/ehsp_params_tb.sv
// Purpose: read-back tests of the structural parameter word
// Assumes: inputs change 1 ns after the rising edge
// Notes: strap moves after reset to show it is latched
`timescale 1ns/1ps
`default_nettype none
module ehsp_params_tb;
    import ehsp_pkg::*;
    logic clock_in = 1'h0, rst_in = 1'h1, strap = 1'h1, rd = 1'h0, wr = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'hFFFF_FFFF, rdat;
    logic vld, ind, hand;
    int miscompares = 0, checks_done = 0;
    ehsp_params ehsp_params_inst (.clock_in(clock_in), .rst_in(rst_in),
        .amber_indicator_strap_in(strap), .rd_en_in(rd), .wr_en_in(wr),
        .addr_in(addr), .wr_data_in(wdat), .rd_data_out(rdat),
        .rd_valid_out(vld), .port_indicator_out(ind),
        .handoff_enable_out(hand));
    initial forever #20 clock_in = ~clock_in;
    task automatic chk(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rd_word(input logic [7:0] a, input logic [31:0] e);
        addr = a;
        rd = 1;
        @(posedge clock_in) #1;
        chk("rd_valid_out", 32'h1, {31'h0, vld});
        chk("rd_data_out", e, rdat);
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        rst_in = 1;
        repeat (4) @(posedge clock_in) #1;
        rst_in = 0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset(1);
        rd_word(8'h04, 32'h0001_2294);
        chk("handoff_enable_out", 32'h1, {31'h0, hand});
        addr = 8'h04;
        rd = 0;
        wr = 1;
        @(posedge clock_in) #1 wr = 0;
        rd_word(8'h04, 32'h0001_2294);
        rd_word(8'h00, 32'h0);
        rd_word(8'h08, 32'h0);
        rd_word(8'h10, 32'h0);
        $display("test read and write done");
        strap = 0;
        repeat (3) @(posedge clock_in) #1;
        rd_word(8'h04, 32'h0001_2294);
        do_reset(0);
        rd_word(8'h04, 32'h0000_2294);
        chk("port_indicator_out", 32'h0, {31'h0, ind});
        rd = 0;
        @(posedge clock_in) #1;
        chk("rd_valid_out", 32'h0, {31'h0, vld});
        $display("test strap done");
        complete_run();
    end
    initial begin
        #10000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire

// file: hw/ehsp_params.sv
// Purpose: host structural parameter register of the high-speed host function
// Assumes: read strobe with byte offset inside the function's memory window
// Notes: read-only; writes are accepted and ignored
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bits 23..20 hold the debug root port number, zero for none.
// - the debug port number never exceeds the reported port count.
// - bit 16 set means every port register has an indicator field.
// - the indicator support bit follows the amber strap during reset.
// - a zero companion count means no companions and no hand-off.
// - a nonzero companion count means companions and hand-off exist.
// - bits 11..8 give ports per companion, grouped in ascending order.
// - companion count times ports per companion covers every port.
// - bit 7 tells which method maps root ports to companions.
// - the word sits at 04h from the memory base held in the BAR at 10h.
// - routing bit zero means ordered grouping, one the explicit array.
// - bit 4 is one when port power switches are present.
// - bits 3..0 give the port count, 1h to Fh.
module ehsp_params
    import ehsp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic amber_indicator_strap_in,
    input wire logic rd_en_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    output logic [31:0] rd_data_out,
    output logic rd_valid_out,
    output logic port_indicator_out,
    output logic handoff_enable_out
);
    // strap is an off-chip level, so it passes two flops before use
    logic strap_s1_reg;
    logic strap_s1_next;
    logic strap_s2_reg;
    logic strap_s2_next;
    logic indicator_reg;
    logic indicator_next;

    logic rd_take;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic handoff_reg;
    logic handoff_next;
    logic unused_write;

    // fields of the word, all constant except the strap bit
    logic [31:0] structural_param_word;
    logic [3:0] debug_port_number;
    logic [3:0] companion_count;
    logic [3:0] ports_per_companion;
    logic routing_method_flag;
    logic power_switch_present;
    logic [3:0] port_count;

    // true when a read targets this word; every other offset reads zero
    function automatic logic ehsp_selects_word(input logic [7:0] offset);
        return offset == EHSP_REG_OFFSET;
    endfunction

    // a zero port count is undefined for software, so it is raised to one
    function automatic logic [3:0] ehsp_limit_ports(input logic [3:0] count);
        logic [3:0] limited;

        limited = count;
        if (count < EHSP_NPORT_MIN) begin
            limited = EHSP_NPORT_MIN;
        end
        return limited;
    endfunction

    // a debug port beyond the last port would point software at nothing
    function automatic logic [3:0] ehsp_limit_debug(
        input logic [3:0] number,
        input logic [3:0] ports
    );
        logic [3:0] limited;

        limited = number;
        if (number > ports) begin
            limited = EHSP_DEBUG_PORT_RST;
        end
        return limited;
    endfunction

    // groups that fall short of the port count would leave ports unrouted
    function automatic logic [3:0] ehsp_fit_group(
        input logic [3:0] companions,
        input logic [3:0] per_group,
        input logic [3:0] ports
    );
        logic [7:0] covered;
        logic [3:0] fitted;

        covered = {4'h0, companions} * {4'h0, per_group};
        fitted = per_group;
        if (companions != EHSP_COUNT_NONE
            && covered < {4'h0, ports}) begin
            fitted = ports;
        end
        return fitted;
    endfunction

    // reserved positions stay zero because the word starts from all zeros
    function automatic logic [31:0] ehsp_pack_word(
        input logic [3:0] debug_port,
        input logic indicator,
        input logic [3:0] companions,
        input logic [3:0] per_group,
        input logic routing,
        input logic power,
        input logic [3:0] ports
    );
        logic [31:0] word;

        word = EHSP_ZERO;
        word[EHSP_DEBUG_PORT_LSB +: EHSP_FIELD_W] = debug_port;
        word[EHSP_IND_BIT] = indicator;
        word[EHSP_COMP_CNT_LSB +: EHSP_FIELD_W] = companions;
        word[EHSP_PER_COMP_LSB +: EHSP_FIELD_W] = per_group;
        word[EHSP_ROUTE_BIT] = routing;
        word[EHSP_POWER_BIT] = power;
        word[EHSP_NPORT_LSB +: EHSP_FIELD_W] = ports;
        return word;
    endfunction

    // every field but bit 16 is fixed; the functions keep the fixed values
    // self-consistent should anyone edit the constants later
    always_comb begin
        port_count = ehsp_limit_ports(EHSP_NPORT_RST);
        debug_port_number = ehsp_limit_debug(
            EHSP_DEBUG_PORT_RST,
            port_count
        );
        companion_count = EHSP_COMP_CNT_RST;
        ports_per_companion = ehsp_fit_group(
            companion_count,
            EHSP_PER_COMP_RST,
            port_count
        );
        routing_method_flag = EHSP_ROUTE_RST;
        power_switch_present = EHSP_POWER_RST;
        structural_param_word = ehsp_pack_word(
            debug_port_number,
            indicator_reg,
            companion_count,
            ports_per_companion,
            routing_method_flag,
            power_switch_present,
            port_count
        );
    end

    // the first flop may go metastable, so only the second one is read
    always_comb begin
        strap_s1_next = amber_indicator_strap_in;
        strap_s2_next = strap_s1_reg;
    end

    always_ff @(posedge clock_in) begin
        strap_s1_reg <= strap_s1_next;
        strap_s2_reg <= strap_s2_next;
    end

    // the latch follows the strap only while reset is high, so a strap
    // that moves later is ignored until the next reset
    always_comb begin
        indicator_next = indicator_reg;
        if (rst_in) begin
            indicator_next = strap_s2_reg;
        end
    end

    always_ff @(posedge clock_in) begin
        indicator_reg <= indicator_next;
    end

    // writes have no path into any field; they only feed this sink
    assign unused_write = wr_en_in ^ (^wr_data_in);

    always_comb begin
        rd_take = rd_en_in && !rst_in;
        rd_valid_next = rd_take;
        rd_data_next = EHSP_ZERO;
        if (rd_take) begin
            if (ehsp_selects_word(addr_in)) begin
                rd_data_next = structural_param_word;
            end
        end
    end

    // the answer is registered so the read port comes straight from flops
    always_ff @(posedge clock_in) begin
        rd_data_reg <= rd_data_next;
        rd_valid_reg <= rd_valid_next;
    end

    // hand-off follows the companion count, so it can never disagree
    always_comb begin
        handoff_next = companion_count != EHSP_COUNT_NONE;
    end

    always_ff @(posedge clock_in) begin
        handoff_reg <= handoff_next;
    end

    // outputs are plain copies of flops
    assign rd_data_out = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;
    assign port_indicator_out = indicator_reg;
    assign handoff_enable_out = handoff_reg;
endmodule

`default_nettype wire

// file: hw/ehsp_pkg.sv
// Purpose: constants for the structural parameter register
// Assumes: 32-bit read-only word at offset 04h of the memory window
// Notes: field positions and reset values named once here
package ehsp_pkg;
    localparam logic [7:0] EHSP_BAR_OFFSET = 8'h10;
    localparam logic [7:0] EHSP_REG_OFFSET = 8'h04;
    localparam int EHSP_FIELD_W = 4;
    localparam int EHSP_DEBUG_PORT_LSB = 20;
    localparam int EHSP_IND_BIT = 16;
    localparam int EHSP_COMP_CNT_LSB = 12;
    localparam int EHSP_PER_COMP_LSB = 8;
    localparam int EHSP_ROUTE_BIT = 7;
    localparam int EHSP_POWER_BIT = 4;
    localparam int EHSP_NPORT_LSB = 0;
    localparam logic [3:0] EHSP_COUNT_NONE = 4'h0;
    localparam logic [3:0] EHSP_DEBUG_PORT_RST = 4'h0;
    localparam logic [3:0] EHSP_COMP_CNT_RST = 4'h2;
    localparam logic [3:0] EHSP_PER_COMP_RST = 4'h2;
    localparam logic EHSP_ROUTE_RST = 1'h1;
    localparam logic EHSP_POWER_RST = 1'h1;
    localparam logic [3:0] EHSP_NPORT_RST = 4'h4;
    localparam logic [3:0] EHSP_NPORT_MIN = 4'h1;
    localparam logic [31:0] EHSP_ZERO = 32'h0000_0000;
endpackage
